// ### rtl/lwr_pkg.sv
// Constants shared by the wake output routing block: register map,
// field positions, reset values and the artificial wake timing.
// Assumes a single 20 MHz clock and a 32-bit AHB-Lite register bus.
package lwr_pkg;

	// Clock rate of hclk
	localparam longint unsigned LWR_CLK_HZ = 64'd20000000;

	// Artificial wake spacing, 2 h 16 min 32 s, in seconds
	localparam longint unsigned LWR_AWAKE_PERIOD_S = 64'd8192;
	localparam longint unsigned LWR_AWAKE_CYCLES = LWR_AWAKE_PERIOD_S * LWR_CLK_HZ;
	localparam int LWR_AWAKE_W = 38;

	// Register byte offsets
	localparam logic [7:0] LWR_POWER_OFS = 8'h00;
	localparam logic [7:0] LWR_CHAN_OFS = 8'h04;
	localparam logic [7:0] LWR_TEST_OFS = 8'h08;
	localparam logic [7:0] LWR_CORR_OFS = 8'h0c;
	localparam logic [7:0] LWR_STAT_OFS = 8'h10;

	// Power register fields
	localparam int LWR_P_CHAN_EN = 0;
	localparam int LWR_P_ANT_A = 4;
	localparam int LWR_P_ANT_B = 5;

	// Channel select register fields
	localparam int LWR_C_SEL_LO = 0;
	localparam int LWR_C_SEL_HI = 1;
	localparam int LWR_C_RSSI_LO = 2;
	localparam int LWR_C_RSSI_HI = 3;
	localparam int LWR_C_DAMP = 4;
	localparam int LWR_C_RELEASE = 5;

	// Test register fields
	localparam int LWR_T_ROUTE_EN = 0;
	localparam int LWR_T_SEL_LO = 1;
	localparam int LWR_T_SEL_HI = 2;
	localparam int LWR_T_STEP = 4;
	localparam int LWR_T_AWAKE_EN = 5;

	// Correlator register fields
	localparam int LWR_M_CORR_OFF = 0;
	localparam int LWR_M_DOUBLE = 1;
	localparam int LWR_M_ZB_LO = 2;
	localparam int LWR_M_ZB_HI = 3;
	localparam int LWR_M_TAU = 4;

	// Status register fields
	localparam int LWR_S_LATCH = 0;
	localparam int LWR_S_CHAN = 1;
	localparam int LWR_S_ART = 4;
	localparam int LWR_S_CS = 5;
	localparam int LWR_S_DATA = 6;

	// Values after reset and writable bit masks
	localparam logic [5:0] LWR_POWER_RST = 6'h00;
	localparam logic [5:0] LWR_CHAN_RST = 6'h00;
	localparam logic [5:0] LWR_TEST_RST = 6'h10;
	localparam logic [5:0] LWR_CORR_RST = 6'h18;
	localparam logic [5:0] LWR_POWER_MASK = 6'h37;
	localparam logic [5:0] LWR_CHAN_MASK = 6'h3f;
	localparam logic [5:0] LWR_TEST_MASK = 6'h37;
	localparam logic [5:0] LWR_CORR_MASK = 6'h1f;

	// Largest zero half-bit tolerance the correlators accept
	localparam logic [1:0] LWR_ZB_MAX = 2'h2;

	// Source driven onto a digital output pin
	typedef enum logic [1:0] {
		LWR_SRC_COMBINED,
		LWR_SRC_DATA,
		LWR_SRC_WAKE,
		LWR_SRC_IDLE
	} lwr_src_e;

endpackage

// ### rtl/lwr_wake_route.sv
// Wake output routing, artificial wake generator and receiver control
// bits of a three-channel LF wake receiver, with an AHB-Lite slave.
// Assumes channel wake/data and chip select arrive asynchronously;
// the pad ring turns rssi_out/rssi_oe_n into a tristate pin.
//
// What this block does
// - level_step_high selects high RSSI step, zero selects low step.
// - Two antenna route bits pick one of three antenna connection modes.
// - Both antenna route bits set short all differential inputs.
// - input_damping_enable switches damping resistor across channel inputs.
// - Digital RSSI mode with channel select 11 puts combined wake on RSSI.
// - RSSI pin driven only while chip select high, else high impedance.
// - Normally the wake pin shows the OR of all three channel wakes.
// - Test route with select 01 puts selected channel wake on wake pin.
// - Test route with select 00 puts selected channel data on wake pin.
// - Routed data is the raw detector stream fed to the correlator.
// - Digital RSSI mode puts the selected single-channel signal on RSSI pin.
// - Per-channel wakes stay readable until cleared; controller checks first.
// - Combined wake pin and single-channel RSSI pin work at once.
// - Enabled generator raises a wake every 2 h 16 min 32 s.
// - Generator counter runs from reset; artificial_wake_enable only gates its wakes.
// - First artificial wake comes anywhere within one period of enabling.
// - Generator counter is reset only by hresetn, never by wake clearing.
// - Correlators tolerate zero to two invalid zero half-bits.
// - threshold_tau_large picks large or small threshold filter constant.
// - wake_release high forces wake pin high, except in test data route (select 00); writing zero re-arms.
// - Wake pin asserted after power-on until release toggled.
module lwr_wake_route
	import lwr_pkg::*;
#(
	parameter longint unsigned AWAKE_CYCLES = LWR_AWAKE_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [2:0] chan_wake,
	input wire logic [2:0] chan_data,
	input wire logic chip_select,
	output logic wake_n,
	output logic rssi_out,
	output logic rssi_oe_n,
	output logic rssi_analog_en,
	output logic [2:0] chan_enable,
	output logic [1:0] antenna_route,
	output logic input_short,
	output logic input_damping_enable,
	output logic level_step_high,
	output logic threshold_tau_large,
	output logic [1:0] zero_bit_tolerance,
	output logic correlator_off,
	output logic double_pattern
);

	// Register map: four six-bit control words and one status word.
	// Only bits [5:0] of each write are kept; the rest read as zero.
	// Reserved bits are masked on write so software cannot set them,
	// while the unused test select codes 1x stay writable and idle the pin high.
	// Unmapped offsets answer OKAY with zero data; no error response
	// is ever raised, so a wrong address is silent to the master.
	// Registers written by software
	logic [5:0] power_reg;
	logic [5:0] chan_reg;
	logic [5:0] test_reg;
	logic [5:0] corr_reg;

	// Bus pipeline state
	logic wr_pend_reg;
	logic rd_pend_reg;
	logic hit_reg;
	logic [7:0] addr_reg;
	logic hreadyout_reg;
	logic [31:0] hrdata_reg;

	// Synchronisers for asynchronous inputs: stage one, stage two
	logic [6:0] meta_reg;
	logic [6:0] sync_reg;

	// Wake state
	logic wake_latch_reg;
	logic [2:0] chan_sticky_reg;
	logic art_sticky_reg;
	logic [LWR_AWAKE_W-1:0] awake_cnt_reg;
	logic awake_pulse_reg;

	// Pin and control output flops
	logic wake_n_reg;
	logic rssi_out_reg;
	logic rssi_oe_n_reg;
	logic rssi_analog_reg;
	logic [2:0] chan_en_reg;
	logic [1:0] ant_reg;
	logic short_reg;
	logic damp_reg;
	logic step_reg;
	logic tau_reg;
	logic [1:0] zb_reg;
	logic corr_off_reg;
	logic double_reg;

	// Address phase decode
	wire take = hsel & htrans[1] & hready;
	wire addr_hit = (haddr[31:8] == 24'h000000);

	// Data phase write strobes, unmapped writes fall through unused
	wire wr_ok = wr_pend_reg & hit_reg;
	wire wr_power = wr_ok & (addr_reg == LWR_POWER_OFS);
	wire wr_chan = wr_ok & (addr_reg == LWR_CHAN_OFS);
	wire wr_test = wr_ok & (addr_reg == LWR_TEST_OFS);
	wire wr_corr = wr_ok & (addr_reg == LWR_CORR_OFS);
	wire [5:0] wdata6 = hwdata[5:0];

	// Synchronised views
	wire [2:0] wake_sync = sync_reg[2:0];
	wire [2:0] data_sync = sync_reg[5:3];
	wire cs_sync = sync_reg[6];

	// Decoded control bits
	wire [1:0] chan_sel = {chan_reg[LWR_C_SEL_HI], chan_reg[LWR_C_SEL_LO]};
	wire [1:0] test_sel = {test_reg[LWR_T_SEL_HI], test_reg[LWR_T_SEL_LO]};
	wire test_route_enable = test_reg[LWR_T_ROUTE_EN];
	wire wake_release = chan_reg[LWR_C_RELEASE];
	wire artificial_wake_enable = test_reg[LWR_T_AWAKE_EN];
	wire rssi_digital = chan_reg[LWR_C_RSSI_HI] & ~chan_reg[LWR_C_RSSI_LO];
	wire [1:0] zb_code = {corr_reg[LWR_M_ZB_HI], corr_reg[LWR_M_ZB_LO]};

	// Status word and read mux
	wire [31:0] stat_word = {23'h000000, data_sync, cs_sync, art_sticky_reg, chan_sticky_reg, wake_latch_reg};
	wire [31:0] rdata_mux =
		~hit_reg ? 32'h00000000 :
		(addr_reg == LWR_POWER_OFS) ? {26'h0000000, power_reg} :
		(addr_reg == LWR_CHAN_OFS) ? {26'h0000000, chan_reg} :
		(addr_reg == LWR_TEST_OFS) ? {26'h0000000, test_reg} :
		(addr_reg == LWR_CORR_OFS) ? {26'h0000000, corr_reg} :
		(addr_reg == LWR_STAT_OFS) ? stat_word : 32'h00000000;

	wire awake_wrap = (awake_cnt_reg == LWR_AWAKE_W'(AWAKE_CYCLES - 64'd1));
	wire [LWR_AWAKE_W-1:0] awake_cnt_next = awake_wrap ? '0 : awake_cnt_reg + LWR_AWAKE_W'(1);

	// Channel wakes gated by channel enables
	wire [2:0] chan_hit = wake_sync & chan_en_reg;
	wire wake_set = (|chan_hit) | awake_pulse_reg;

	// Channel select 11 picks no single channel; padded lane reads zero
	wire [3:0] sticky_pad = {1'b0, chan_sticky_reg};
	wire [3:0] data_pad = {1'b0, data_sync};
	// Raw detector stream of chosen channel
	wire sel_data = data_pad[chan_sel];
	// Sticky single-channel wake of chosen channel
	wire sel_wake = sticky_pad[chan_sel];

	// Test selection onto a pin; codes 1x are unused and idle high
	wire lwr_src_e test_src =
		(test_sel == 2'b00) ? LWR_SRC_DATA :
		(test_sel == 2'b01) ? LWR_SRC_WAKE : LWR_SRC_IDLE;
	// Channel select 11 on RSSI means combined wake
	wire lwr_src_e rssi_src = (chan_sel == 2'b11) ? LWR_SRC_COMBINED : test_src;
	// Normal wake pin shows the combined latch
	wire lwr_src_e wake_src = test_route_enable ? test_src : LWR_SRC_COMBINED;

	// Pin levels; wakes are active low, data passes true
	wire wake_pin_next =
		(wake_src == LWR_SRC_COMBINED) ? ~wake_latch_reg :
		(wake_src == LWR_SRC_DATA) ? sel_data :
		(wake_src == LWR_SRC_WAKE) ? ~sel_wake : 1'b1;
	wire rssi_pin_next =
		(rssi_src == LWR_SRC_COMBINED) ? ~wake_latch_reg :
		(rssi_src == LWR_SRC_DATA) ? sel_data :
		(rssi_src == LWR_SRC_WAKE) ? ~sel_wake : 1'b1;

	// Code 00 would ask for three invalid half-bits, more than the
	// correlators support; it is clamped rather than refused so an
	// old setting still gives the most tolerant legal behaviour.
	// Tolerance saturates at two, so code 00 gives two
	wire [1:0] zb_next =
		(zb_code == 2'b11) ? 2'h0 :
		(zb_code == 2'b10) ? 2'h1 : LWR_ZB_MAX;

	// Channel wake, detector data and chip select come from the
	// analog side and the controller, not from hclk, so every one is
	// resynchronised before use. The two-cycle latency is part of the
	// wake timing the controller sees and is not hidden anywhere.
	// Two-flop synchronisers; stage one read only by stage two
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= {chip_select, chan_data, chan_wake};
			sync_reg <= meta_reg;
		end
	end

	// Address phase capture; read takes one wait state so a write
	// in the preceding data phase is always seen by the read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			hit_reg <= 1'b0;
			addr_reg <= 8'h00;
			hreadyout_reg <= 1'b1;
			hrdata_reg <= 32'h00000000;
		end else begin
			wr_pend_reg <= take & hwrite;
			rd_pend_reg <= take & ~hwrite;
			if (take) begin
				hit_reg <= addr_hit;
				addr_reg <= haddr[7:0];
			end
			if (take & ~hwrite) begin
				hreadyout_reg <= 1'b0;
			end else if (rd_pend_reg) begin
				hreadyout_reg <= 1'b1;
				hrdata_reg <= rdata_mux;
			end
		end
	end

	// Register writes in the data phase; reserved bits stay zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			power_reg <= LWR_POWER_RST;
			chan_reg <= LWR_CHAN_RST;
			test_reg <= LWR_TEST_RST;
			corr_reg <= LWR_CORR_RST;
		end else begin
			if (wr_power)
				power_reg <= wdata6 & LWR_POWER_MASK;
			if (wr_chan)
				chan_reg <= wdata6 & LWR_CHAN_MASK;
			if (wr_test)
				test_reg <= wdata6 & LWR_TEST_MASK;
			if (wr_corr)
				corr_reg <= wdata6 & LWR_CORR_MASK;
		end
	end

	// The counter is deliberately not gated by the enable bit: it runs
	// from reset, and the enable only masks the overflow request. This
	// costs a little power but keeps the period fixed once enabled.
	// Limitation: the first wake after enabling lands anywhere in the
	// first period, so software must not time anything from the enable.
	// Counter cleared only by power-on reset, never by release
	// Free phase against the enable gives an undefined first wake
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			awake_cnt_reg <= '0;
			awake_pulse_reg <= 1'b0;
		end else begin
			awake_cnt_reg <= awake_cnt_next;
			awake_pulse_reg <= awake_wrap & artificial_wake_enable;
		end
	end

	// The latch is the single source of the combined wake; both pins
	// read it, so the two views can never disagree. Release is a level,
	// not a pulse: while it stays high every new wake is dropped, which
	// is why software must write it back to zero promptly.
	// A wake arriving in the same cycle as release is lost by design.
	// Latch comes up set after power-on
	// Release held high keeps latch clear, winning over new wakes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_latch_reg <= 1'b1;
		end else if (wake_release) begin
			wake_latch_reg <= 1'b0;
		end else if (wake_set) begin
			wake_latch_reg <= 1'b1;
		end
	end

	// Artificial flag lets software tell the sources apart
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chan_sticky_reg <= 3'h0;
			art_sticky_reg <= 1'b0;
		end else if (wake_release) begin
			chan_sticky_reg <= 3'h0;
			art_sticky_reg <= 1'b0;
		end else begin
			chan_sticky_reg <= chan_sticky_reg | chan_hit;
			art_sticky_reg <= art_sticky_reg | awake_pulse_reg;
		end
	end

	// Pin drivers are flopped so a change of routing never glitches a
	// pin the controller may be watching on an interrupt input. The
	// RSSI driver enable follows the synchronised chip select, so the
	// pin floats for a few cycles after select rises; that settling
	// delay is the price of keeping the select pin glitch safe.
	// Single wake on wake pin in test route
	// Data stream on wake pin in test route
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_n_reg <= 1'b0;
			rssi_out_reg <= 1'b1;
			rssi_oe_n_reg <= 1'b1;
			rssi_analog_reg <= 1'b0;
		end else begin
			wake_n_reg <= wake_pin_next;
			// Digital RSSI carries the chosen signal
			rssi_out_reg <= rssi_pin_next;
			// Driver off whenever chip select is low
			rssi_oe_n_reg <= ~(cs_sync & rssi_digital);
			rssi_analog_reg <= cs_sync & ~rssi_digital;
		end
	end

	// These bits steer switches and bias in the analog front end. Each
	// takes effect one cycle after the register write, which is far
	// below any settling time of the analog parts, so no handshake is
	// needed with the front end.
	// Analog and correlator control, flopped so outputs never glitch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chan_en_reg <= 3'h0;
			ant_reg <= 2'h0;
			short_reg <= 1'b0;
			damp_reg <= 1'b0;
			step_reg <= 1'b1;
			tau_reg <= 1'b1;
			zb_reg <= LWR_ZB_MAX;
			corr_off_reg <= 1'b0;
			double_reg <= 1'b0;
		end else begin
			chan_en_reg <= power_reg[LWR_P_CHAN_EN +: 3];
			ant_reg <= {power_reg[LWR_P_ANT_B], power_reg[LWR_P_ANT_A]};
			// Both route bits short the inputs
			short_reg <= power_reg[LWR_P_ANT_B] & power_reg[LWR_P_ANT_A];
			damp_reg <= chan_reg[LWR_C_DAMP];
			step_reg <= test_reg[LWR_T_STEP];
			tau_reg <= corr_reg[LWR_M_TAU];
			zb_reg <= zb_next;
			corr_off_reg <= corr_reg[LWR_M_CORR_OFF];
			double_reg <= corr_reg[LWR_M_DOUBLE];
		end
	end

	// Outputs straight from flops, hresp tied low
	assign hreadyout = hreadyout_reg;
	assign hrdata = hrdata_reg;
	assign hresp = 1'b0;
	assign wake_n = wake_n_reg;
	assign rssi_out = rssi_out_reg;
	assign rssi_oe_n = rssi_oe_n_reg;
	assign rssi_analog_en = rssi_analog_reg;
	assign chan_enable = chan_en_reg;
	assign antenna_route = ant_reg;
	assign input_short = short_reg;
	assign input_damping_enable = damp_reg;
	assign level_step_high = step_reg;
	assign threshold_tau_large = tau_reg;
	assign zero_bit_tolerance = zb_reg;
	assign correlator_off = corr_off_reg;
	assign double_pattern = double_reg;

endmodule

// ### test/lwr_wake_route_asserts.sv
// Checker for the wake output routing block, bound to its top module.
// Assumes single word AHB-Lite writes and a quiet bus during resets.
module lwr_wake_route_asserts
	import lwr_pkg::*;
#(
	parameter longint unsigned AWAKE_CYCLES = LWR_AWAKE_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [2:0] chan_wake,
	input wire logic chip_select,
	input wire logic wake_n,
	input wire logic rssi_oe_n,
	input wire logic [2:0] chan_enable,
	input wire logic [1:0] antenna_route,
	input wire logic input_short,
	input wire logic input_damping_enable,
	input wire logic level_step_high,
	input wire logic [1:0] zero_bit_tolerance
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic ap_wr;
	logic [7:0] ap_a;
	logic rel_q;
	logic test_en;
	// Data phase of a write, per register
	wire dp_pow = ap_wr && ap_a == LWR_POWER_OFS;
	wire dp_chan = ap_wr && ap_a == LWR_CHAN_OFS;
	wire dp_test = ap_wr && ap_a == LWR_TEST_OFS;
	wire dp_corr = ap_wr && ap_a == LWR_CORR_OFS;
	// Mirrors of release and test route; the pin depends on both
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr <= 1'b0;
			ap_a <= 8'h00;
			rel_q <= 1'b0;
			test_en <= 1'b0;
		end else begin
			ap_wr <= hsel && htrans[1] && hready && hwrite && haddr[31:8] == 24'h0;
			ap_a <= haddr[7:0];
			if (dp_chan)
				rel_q <= hwdata[LWR_C_RELEASE];
			if (dp_test)
				test_en <= hwdata[LWR_T_ROUTE_EN];
		end
	end
	property p_rssi_hiz; !chip_select [*4] |-> rssi_oe_n; endproperty
	a_rssi_hiz: assert property (p_rssi_hiz) else $error("rssi driven without select");
	property p_route; dp_pow |-> ##2 {antenna_route, input_short} == {$past(hwdata[5:4], 2), &$past(hwdata[5:4], 2)};
	endproperty
	a_route: assert property (p_route) else $error("antenna route wrong");
	property p_step; dp_test |-> ##2 level_step_high == $past(hwdata[LWR_T_STEP], 2); endproperty
	a_step: assert property (p_step) else $error("step select wrong");
	property p_damp; dp_chan |-> ##2 input_damping_enable == $past(hwdata[LWR_C_DAMP], 2); endproperty
	a_damp: assert property (p_damp) else $error("damping wrong");
	property p_zb; dp_corr |-> ##2 zero_bit_tolerance == ($past(hwdata[3:2], 2) == 2'h3 ? 2'h0 :
		$past(hwdata[3:2], 2) == 2'h2 ? 2'h1 : 2'h2); endproperty
	a_zb: assert property (p_zb) else $error("zero bit tolerance wrong");
	property p_release; dp_chan && hwdata[LWR_C_RELEASE] && !test_en |-> ##3 wake_n ##1 wake_n; endproperty
	a_release: assert property (p_release) else $error("release did not raise wake");
	property p_hold; (!test_en && !rel_q) [*3] ##0 !wake_n ##1 !rel_q |-> !wake_n; endproperty
	a_hold: assert property (p_hold) else $error("wake dropped without release");
	property p_wake; !test_en && !rel_q && |(chan_wake & chan_enable) |-> ##[1:6] !wake_n; endproperty
	a_wake: assert property (p_wake) else $error("channel wake not shown");
endmodule

bind lwr_wake_route lwr_wake_route_asserts #(.AWAKE_CYCLES(AWAKE_CYCLES)) u_chk (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .chan_wake, .chip_select, .wake_n, .rssi_oe_n, .chan_enable,
	.antenna_route, .input_short, .input_damping_enable, .level_step_high, .zero_bit_tolerance);

// ### test/lwr_far_end.sv
// Far side model: receive channel pins, chip select, and the controller
// counting wake events. Assumes the bench sets levels by request inputs.
module lwr_far_end (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [2:0] wake_req,
	input wire logic [2:0] data_req,
	input wire logic cs_req,
	input wire logic wake_n,
	output logic [2:0] chan_wake,
	output logic [2:0] chan_data,
	output logic chip_select,
	output int wake_events
);
	logic wake_n_q;
	// Pins move just after the edge; falls of the wake pin are counted
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chan_wake <= 3'h0;
			chan_data <= 3'h0;
			chip_select <= 1'b0;
			wake_n_q <= 1'b0;
			wake_events <= 0;
		end else begin
			chan_wake <= wake_req;
			chan_data <= data_req;
			chip_select <= cs_req;
			wake_n_q <= wake_n;
			if (wake_n_q && !wake_n)
				wake_events <= wake_events + 1;
		end
	end
endmodule

// ### test/testbench.sv
// Self-checking bench for the wake output routing block.
// Assumes the far-side model drives channel pins and chip select.
module testbench
	import lwr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// Short artificial wake period keeps the run brief
	localparam int PER = 64;
	logic hclk = 1'b0;
	logic hresetn;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [2:0] wake_req = 3'h0;
	logic [2:0] data_req = 3'h0;
	logic cs_req = 1'b0;
	logic hready, hreadyout, hresp, chip_select, wake_n, rssi_out, rssi_oe_n, rssi_analog_en, input_short;
	logic input_damping_enable, level_step_high, threshold_tau_large, correlator_off, double_pattern;
	logic [31:0] hrdata;
	logic [2:0] chan_wake, chan_data, chan_enable;
	logic [1:0] antenna_route, zero_bit_tolerance;
	int fails = 0;
	int num_checks = 0;
	int cyc = 0;
	int wake_events;
	assign hready = hreadyout;
	// 50 ns clock and a cycle count for interval checks
	initial begin
		forever #25 hclk = ~hclk;
	end
	always @(posedge hclk) cyc <= cyc + 1;
	lwr_wake_route #(.AWAKE_CYCLES(PER)) u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hrdata, .hresp, .chan_wake, .chan_data, .chip_select, .wake_n, .rssi_out, .rssi_oe_n,
		.rssi_analog_en, .chan_enable, .antenna_route, .input_short, .input_damping_enable, .level_step_high,
		.threshold_tau_large, .zero_bit_tolerance, .correlator_off, .double_pattern);
	lwr_far_end u_far (.hclk, .hresetn, .wake_req, .data_req, .cs_req, .wake_n, .chan_wake, .chan_data,
		.chip_select, .wake_events);
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Bounded waits; running out ends the run as a failure
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 16) begin
				fails++;
				test_done();
			end
			@(posedge hclk);
		end
	endtask
	task automatic wait_low(input int lim);
		int n;
		n = 0;
		while (wake_n !== 1'b0) begin
			n++;
			if (n > lim) begin
				fails++;
				test_done();
			end
			@(posedge hclk);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// One single transfer: address phase, then data phase
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task automatic clear();
		wr(LWR_CHAN_OFS, 32'h20);
		wr(LWR_CHAN_OFS, 32'h00);
		idle(2);
	endtask
	task automatic t_reset();
		logic [31:0] r;
		chk("wake_n", wake_n, 1'b0);
		chk("rssi_oe_n", rssi_oe_n, 1'b1);
		chk("step", level_step_high, 1'b1);
		chk("hresp", hresp, 1'b0);
		xfer(1'b0, LWR_TEST_OFS, 32'h0, r);
		chk("test reg", r, 32'h10);
		xfer(1'b0, LWR_CORR_OFS, 32'h0, r);
		chk("corr reg", r, 32'h18);
		xfer(1'b0, 8'h40, 32'h0, r);
		chk("unmapped", r, 32'h0);
		clear();
		chk("wake_n", wake_n, 1'b1);
	endtask
	task automatic t_ctrl();
		wr(LWR_POWER_OFS, 32'h37);
		idle(2);
		chk("route", {antenna_route, input_short}, 3'h7);
		chk("chan enable", chan_enable, 3'h7);
		wr(LWR_POWER_OFS, 32'h27);
		wr(LWR_CHAN_OFS, 32'h10);
		wr(LWR_TEST_OFS, 32'h00);
		idle(2);
		chk("route", {antenna_route, input_short}, 3'h4);
		chk("damp", input_damping_enable, 1'b1);
		chk("step", level_step_high, 1'b0);
		for (int i = 0; i < 4; i++) begin
			wr(LWR_CORR_OFS, {28'h0, i[1:0], 2'h0});
			idle(2);
			chk("zero bits", zero_bit_tolerance, i == 3 ? 2'h0 : i == 2 ? 2'h1 : 2'h2);
			chk("tau", threshold_tau_large, 1'b0);
		end
		wr(LWR_CORR_OFS, 32'h13);
		idle(2);
		chk("corr off", correlator_off, 1'b1);
		chk("double", double_pattern, 1'b1);
		wr(LWR_CORR_OFS, 32'h18);
		wr(LWR_CHAN_OFS, 32'h00);
		wr(LWR_POWER_OFS, 32'h07);
		idle(2);
		chk("tau", threshold_tau_large, 1'b1);
		chk("corr off", correlator_off, 1'b0);
	endtask
	task automatic t_wake();
		logic [31:0] r;
		wake_req <= 3'h2;
		wait_low(10);
		chk("wake", wake_n, 1'b0);
		wake_req <= 3'h0;
		xfer(1'b0, LWR_STAT_OFS, 32'h0, r);
		chk("status", r[8:0], 9'h005);
		wr(LWR_CHAN_OFS, 32'h01);
		wr(LWR_TEST_OFS, 32'h03);
		idle(2);
		chk("single wake", wake_n, 1'b0);
		wr(LWR_CHAN_OFS, 32'h00);
		idle(2);
		chk("single wake", wake_n, 1'b1);
		data_req <= 3'h4;
		wr(LWR_CHAN_OFS, 32'h02);
		wr(LWR_TEST_OFS, 32'h01);
		idle(2);
		chk("data", wake_n, 1'b1);
		data_req <= 3'h0;
		idle(5);
		chk("data", wake_n, 1'b0);
		cs_req <= 1'b1;
		wr(LWR_TEST_OFS, 32'h02);
		wr(LWR_CHAN_OFS, 32'h0b);
		idle(2);
		chk("rssi_oe_n", rssi_oe_n, 1'b0);
		chk("rssi combined", rssi_out, 1'b0);
		wr(LWR_CHAN_OFS, 32'h09);
		idle(2);
		chk("rssi single", rssi_out, 1'b0);
		chk("wake", wake_n, 1'b0);
		wr(LWR_CHAN_OFS, 32'h08);
		idle(2);
		chk("rssi single", rssi_out, 1'b1);
		wr(LWR_CHAN_OFS, 32'h00);
		idle(2);
		chk("rssi analog", rssi_analog_en, 1'b1);
		chk("rssi_oe_n", rssi_oe_n, 1'b1);
		cs_req <= 1'b0;
		idle(5);
		chk("rssi_oe_n", rssi_oe_n, 1'b1);
		clear();
		chk("wake_n", wake_n, 1'b1);
	endtask
	task automatic t_art();
		logic [31:0] r;
		int t0;
		int ev;
		wr(LWR_TEST_OFS, 32'h30);
		wait_low(3 * PER);
		t0 = cyc;
		xfer(1'b0, LWR_STAT_OFS, 32'h0, r);
		chk("status", r[4:1], 4'h8);
		clear();
		wait_low(3 * PER);
		chk("period", cyc - t0, PER);
		wr(LWR_TEST_OFS, 32'h10);
		clear();
		ev = wake_events;
		idle(3 * PER);
		chk("events", wake_events, ev);
		chk("wake_n", wake_n, 1'b1);
	endtask
	// Reset for three cycles, then the scenarios in turn
	initial begin
		hresetn = 1'b0;
		idle(3);
		hresetn <= 1'b1;
		idle(1);
		t_reset();
		t_ctrl();
		t_wake();
		t_art();
		test_done();
	end
endmodule
